//--- sar_adc_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH
`define ADDR_STATUS_CONTROL 8'h00
`define ADDR_RESULT_HIGH    8'h04
`define ADDR_RESULT_LOW     8'h08
`define ADDR_CLOCK_CONFIG   8'h0C
`define SC_DONE_BIT         7
`define SC_IRQ_EN_BIT       6
`define SC_CONT_BIT         5
`define CHAN_OFF_CODE       5'h1F
`define SC_RESET            8'h1F
`define CK_RESET            8'h00
`define RESULT_MSB_START    10'h200
`define ROUND_HALF_LSB      11'h002
`define SAMPLE_SHORT_HALVES 7
`define SAMPLE_LONG_HALVES  47
`define SAMPLE_SHORT_TICKS  ((`SAMPLE_SHORT_HALVES + 1) / 2)
`define SAMPLE_LONG_TICKS   ((`SAMPLE_LONG_HALVES + 1) / 2)
`endif

//--- sar_adc_pkg.sv
// types shared by the converter control block
package sar_adc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_SAMPLE  = 3'b010,
        ST_CONVERT = 3'b100
    } conv_state_t;

    typedef enum logic [1:0] {
        MODE_8BIT  = 2'b00,
        MODE_10BIT = 2'b01,
        MODE_RSVD  = 2'b10,
        MODE_10HW  = 2'b11
    } result_mode_t;

    // clock configuration register layout
    typedef struct packed {
        logic         low_power_config;
        logic [1:0]   clock_divide_field;
        logic         input_clock_select;
        result_mode_t mode;
        logic         long_sample_select;
        logic         async_clock_enable;
    } clock_config_t;

    // writable part of the status/control register
    typedef struct packed {
        logic       conversion_irq_enable;
        logic       continuous_select;
        logic [4:0] channel_select;
    } status_control_t;
endpackage

//--- sar_adc_control.sv
// apb register file and conversion sequencer for a 10-bit sar converter
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "sar_adc_defines.svh"
// Summary of operation
// RL1 - control write aborts and restarts unless channel off
// RL2 - done flag sets at end, clears on writes/reads
// RL3 - enabled interrupt at end, cleared by access
// RL4 - continuous mode runs back to back until stopped
// RL5 - stop without async clock halts until control write
// RL6 - continuous control write aborts, starts continuous run
// RL7 - single mode does one conversion per write
// RL8 - five-bit channel code selects inputs and references
// RL9 - all-ones channel powers off, no extra conversion
// RL10 - unused channel codes give undefined results
// RL11 - converter powers down after each single-mode conversion; the block stays powered between continuous conversions
// RL12 - 10-bit high read locks results until low read
// RL13 - 8-bit mode has no result interlock
// RL14 - high register holds only msbs, rest zero
// RL15 - divider field divides input clock by 1,2,4,8
// RL16 - select bit picks bus or alternate clock
// RL17 - mode field picks 8/10-bit; reset gives 8-bit
// RL18 - result rounded to selected width
// RL19 - long sample 23.5 cycles, short 3.5 cycles; code samples 24 and 4 whole ticks
// RL20 - async clock runs only during conversions, survives stop
// RL21 - async clock speed range depends on low power
// RL22 - bus clock fast enough for precise continuous sampling
// RL23 - done flag sets regardless of interrupt enable
// RL24 - stop aborts; results keep last completed value
module sar_adc_control (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata_r,
    output logic             pready_r,
    output logic             pslverr_r,
    input  wire logic        alt_clk_tick,
    input  wire logic        async_clk_tick,
    input  wire logic        stop_mode,
    input  wire logic        cmp_in,
    output logic             async_clk_req_r,
    output logic             low_power_config_r,
    output logic             sar_power_r,
    output logic             sar_sample_r,
    output logic      [4:0]  sar_channel_r,
    output logic      [9:0]  sar_trial_r,
    output logic             irq_r
);
    sar_adc_pkg::conv_state_t     st_r;        // sequencer state
    sar_adc_pkg::conv_state_t     st_nxt;
    sar_adc_pkg::status_control_t sc_r;        // software control fields
    sar_adc_pkg::clock_config_t   ck_r;        // clock / mode config
    logic       done_r;                        // conversion done flag
    logic       lock_r;                        // result interlock
    logic [9:0] res_r;                         // latched result
    logic [2:0] div_cnt_r;                     // converter clock divider
    logic [4:0] samp_cnt_r;                    // sample phase counter
    logic [3:0] bit_r;                         // bit under trial
    logic       conv_tick;                     // one converter clock
    logic       src_tick;                      // selected input clock
    logic [2:0] div_mask;
    logic       xfer;                          // apb access completes
    logic       wr_sc;
    logic       wr_ck;
    logic       rd_hi;
    logic       rd_lo;
    logic       start_req;                     // valid control write
    logic       abort;                         // kill running conversion
    logic       stop_abort;                    // stop without async clock
    logic       complete;                      // last bit decided
    logic [9:0] final_code;
    logic [10:0] round_sum;
    logic [7:0] round8;
    logic       mode8;
    logic       addr_ok;
    logic [4:0] samp_len;

    // apb decode; a request completes on the first access cycle
    assign xfer     = psel && penable && pready_r;
    assign addr_ok  = (paddr == `ADDR_STATUS_CONTROL) ||
                      (paddr == `ADDR_RESULT_HIGH) ||
                      (paddr == `ADDR_RESULT_LOW) ||
                      (paddr == `ADDR_CLOCK_CONFIG);
    assign wr_sc    = xfer && pwrite && paddr == `ADDR_STATUS_CONTROL;
    assign wr_ck    = xfer && pwrite && paddr == `ADDR_CLOCK_CONFIG;
    assign rd_hi    = xfer && !pwrite && paddr == `ADDR_RESULT_HIGH;
    assign rd_lo    = xfer && !pwrite && paddr == `ADDR_RESULT_LOW;
    assign mode8    = ck_r.mode == sar_adc_pkg::MODE_8BIT;

    // an all-ones channel only powers down, it never starts
    assign start_req  = wr_sc && pwdata[4:0] != `CHAN_OFF_CODE; // RL1
    assign stop_abort = stop_mode && !ck_r.async_clock_enable;  // RL20
    assign abort      = wr_sc || wr_ck || stop_abort;           // RL4

    // input clock pick: async source wins, else bus or alternate
    always_comb begin
        if (ck_r.async_clock_enable) begin
            src_tick = async_clk_tick;                          // RL20
        end else if (ck_r.input_clock_select) begin
            src_tick = 1'b1;                                    // RL16
        end else begin
            src_tick = alt_clk_tick;                            // RL16
        end
    end

    // divide by 1, 2, 4 or 8 as a power-of-two mask
    assign div_mask  = 3'((4'h1 << ck_r.clock_divide_field) - 4'h1); // RL15
    assign conv_tick = src_tick && ((div_cnt_r & div_mask) == div_mask);

    // sample length in whole converter ticks; half tick rounded up
    assign samp_len = ck_r.long_sample_select ?
                      5'(`SAMPLE_LONG_TICKS) : 5'(`SAMPLE_SHORT_TICKS); // RL19

    // successive approximation: keep bit if comparator says input >= trial
    assign complete   = st_r == sar_adc_pkg::ST_CONVERT && conv_tick &&
                        bit_r == 4'h0 && !abort;
    assign final_code = cmp_in ? sar_trial_r : (sar_trial_r & 10'h3FE);

    // 8-bit result rounds to nearest code and saturates at full scale
    assign round_sum = {1'b0, final_code} + `ROUND_HALF_LSB;      // RL18
    assign round8    = round_sum[10] ? 8'hFF : round_sum[9:2];    // RL18

    // next-state for the sequencer
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            sar_adc_pkg::ST_IDLE: begin
                if (start_req && !stop_abort) begin
                    st_nxt = sar_adc_pkg::ST_SAMPLE;            // RL7
                end
            end
            sar_adc_pkg::ST_SAMPLE: begin
                if (conv_tick && samp_cnt_r == samp_len - 5'h01) begin
                    st_nxt = sar_adc_pkg::ST_CONVERT;
                end
            end
            sar_adc_pkg::ST_CONVERT: begin
                if (complete) begin
                    // powers down after a conversion unless continuous
                    st_nxt = sc_r.continuous_select ?
                             sar_adc_pkg::ST_SAMPLE :
                             sar_adc_pkg::ST_IDLE;              // RL4 RL11
                end
            end
            default: st_nxt = sar_adc_pkg::ST_IDLE;
        endcase
        // any abort restarts from a fresh sample or goes quiet
        if (abort) begin
            st_nxt = (start_req && !stop_abort) ?
                     sar_adc_pkg::ST_SAMPLE :
                     sar_adc_pkg::ST_IDLE;   // RL1 RL6 RL9 RL24
        end
    end

    // sequencer state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= sar_adc_pkg::ST_IDLE;
        end else begin
            st_r <= st_nxt;                                     // RL5
        end
    end

    // divider only free-runs while converting, so phase starts clean
    always_ff @(posedge clk) begin
        if (sys_rst || st_nxt == sar_adc_pkg::ST_IDLE || abort) begin
            div_cnt_r <= 3'h0;
        end else if (src_tick) begin
            div_cnt_r <= div_cnt_r + 3'h1;
        end
    end

    // sample counter, restarted on entry and on any abort, so a control
    // write landing mid-sample gets a full fresh sample phase
    always_ff @(posedge clk) begin
        if (sys_rst || st_r != sar_adc_pkg::ST_SAMPLE || abort) begin
            samp_cnt_r <= 5'h00;
        end else if (conv_tick) begin
            samp_cnt_r <= samp_cnt_r + 5'h01;
        end
    end

    // trial code and bit pointer for the approximation
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sar_trial_r <= 10'h000;
            bit_r       <= 4'h9;
        end else if (st_nxt == sar_adc_pkg::ST_SAMPLE) begin
            sar_trial_r <= `RESULT_MSB_START;
            bit_r       <= 4'h9;
        end else if (st_r == sar_adc_pkg::ST_CONVERT && conv_tick &&
                     bit_r != 4'h0) begin
            // decide current bit, then try the next lower one
            sar_trial_r <= (cmp_in ? sar_trial_r :
                            (sar_trial_r & ~(10'h001 << bit_r))) |
                           (10'h001 << (bit_r - 4'h1));
            bit_r       <= bit_r - 4'h1;
        end
    end

    // analog side controls; power follows the sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sar_power_r        <= 1'b0;
            sar_sample_r       <= 1'b0;
            async_clk_req_r    <= 1'b0;
            low_power_config_r <= 1'b0;
        end else begin
            sar_power_r        <= st_nxt != sar_adc_pkg::ST_IDLE;   // RL9 RL11
            sar_sample_r       <= st_nxt == sar_adc_pkg::ST_SAMPLE;
            async_clk_req_r    <= ck_r.async_clock_enable &&
                                  st_nxt != sar_adc_pkg::ST_IDLE;  // RL20
            // selects the slower async clock range on the analog side
            low_power_config_r <= ck_r.low_power_config;          // RL21
        end
    end

    // channel goes to the input mux; unused codes give whatever comes
    assign sar_channel_r = sc_r.channel_select;                   // RL8 RL10

    // status/control fields; reset leaves channel off
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sc_r <= sar_adc_pkg::status_control_t'(7'(`SC_RESET));
        end else if (wr_sc) begin
            sc_r <= sar_adc_pkg::status_control_t'(pwdata[6:0]);
        end
    end

    // clock config register; reset value gives 8-bit mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ck_r <= sar_adc_pkg::clock_config_t'(`CK_RESET);      // RL17
        end else if (wr_ck) begin
            ck_r <= sar_adc_pkg::clock_config_t'(pwdata[7:0]);    // RL17
        end
    end

    // done flag; a finishing conversion beats a same-cycle clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            done_r <= 1'b0;
        end else if (complete) begin
            done_r <= 1'b1;                                       // RL2 RL23
        end else if (wr_sc || rd_lo) begin
            done_r <= 1'b0;                                       // RL2
        end
    end

    // interrupt line, set wins over clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_r <= 1'b0;
        end else if (complete && sc_r.conversion_irq_enable) begin
            irq_r <= 1'b1;                                        // RL3
        end else if (wr_sc || rd_hi || rd_lo) begin
            irq_r <= 1'b0;                                        // RL3
        end
    end

    // interlock in every mode except 8-bit; low read releases it
    always_ff @(posedge clk) begin
        if (sys_rst || mode8) begin
            lock_r <= 1'b0;                                       // RL13
        end else if (rd_hi) begin
            lock_r <= 1'b1;                                       // RL12
        end else if (rd_lo) begin
            lock_r <= 1'b0;                                       // RL12
        end
    end

    // result latch; a result finished while locked is dropped
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            res_r <= 10'h000;
        end else if (complete && !lock_r) begin
            res_r <= mode8 ? {2'b00, round8} : final_code;        // RL12 RL18
        end
    end

    // apb answer: ready in the first access cycle, data set up early
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= psel && !penable;
            pslverr_r <= psel && !penable && !addr_ok;
            prdata_r  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `ADDR_STATUS_CONTROL:
                        prdata_r[7:0] <= {done_r, sc_r};
                    `ADDR_RESULT_HIGH:
                        // only msbs in every mode except 8-bit, zero in 8-bit mode
                        prdata_r[1:0] <= mode8 ? 2'b00 : res_r[9:8]; // RL14
                    `ADDR_RESULT_LOW:
                        prdata_r[7:0] <= res_r[7:0];
                    `ADDR_CLOCK_CONFIG:
                        prdata_r[7:0] <= ck_r;
                    default:
                        prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // checks on the sequencer and status
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence sc_write_go_s;
        start_req && !stop_abort;
    endsequence

    sequence sampling_s;
        st_r == sar_adc_pkg::ST_SAMPLE;
    endsequence

    write_starts_a: assert property (sc_write_go_s |=> sampling_s) // RL1
        else $error("control write did not start a sample");

    restart_clean_a: assert property (sc_write_go_s |=> samp_cnt_r == 5'h00) // RL1
        else $error("restart kept an old sample count");

    chan_off_a: assert property ( // RL9
        wr_sc && pwdata[4:0] == `CHAN_OFF_CODE |=>
        st_r == sar_adc_pkg::ST_IDLE ##1 !sar_power_r)
        else $error("all-ones channel left converter running");

    done_sets_a: assert property (complete |=> done_r) // RL23
        else $error("done flag missed a completion");

    done_clears_a: assert property (rd_lo && !complete |=> !done_r) // RL2
        else $error("low read did not clear done");

    irq_on_end_a: assert property ( // RL3
        complete && sc_r.conversion_irq_enable |=> irq_r)
        else $error("interrupt missing at conversion end");

    clock_write_a: assert property ( // RL4
        wr_ck |=> st_r == sar_adc_pkg::ST_IDLE)
        else $error("clock write did not stop conversion");

    stop_halts_a: assert property ( // RL5
        stop_abort && !wr_sc |=> st_r == sar_adc_pkg::ST_IDLE ##1
        (st_r == sar_adc_pkg::ST_IDLE || $past(wr_sc, 2) ||
         $past(wr_sc)))
        else $error("conversion ran on in stop");

    lock_holds_a: assert property (
        lock_r && complete |=> $stable(res_r)) // RL12
        else $error("locked result registers changed");

    high_zero_a: assert property ( // RL14
        psel && !penable && !pwrite && paddr == `ADDR_RESULT_HIGH && mode8
        |=> prdata_r == 32'h0000_0000)
        else $error("high register not zero in 8-bit mode");

    single_stop_a: assert property ( // RL7
        complete && !sc_r.continuous_select && !abort
        |=> st_r == sar_adc_pkg::ST_IDLE)
        else $error("single mode converted again");
endmodule

//--- sar_analog_model.sv
// analog source and comparator facing the converter's trial code
`timescale 1ns/10ps
module sar_analog_model (
    input  wire logic       clk,
    input  wire logic       sar_power_r,
    input  wire logic [9:0] sar_trial_r,
    input  wire logic [9:0] level,
    output logic            cmp_in
);
    logic toggle_r; // changes every cycle while unpowered

    // unpowered comparator has no settled answer, so never a steady level
    always_ff @(posedge clk) begin
        toggle_r <= (toggle_r === 1'b1) ? 1'b0 : 1'b1;
    end

    // comparator high when the held input is at or above the trial code
    assign cmp_in = sar_power_r ? (level >= sar_trial_r) : toggle_r;
endmodule

//--- tb_top.sv
// self-checking bench for the sar converter control block
`timescale 1ns/10ps
`include "sar_adc_defines.svh"
module tb_top;
    localparam logic [7:0] SC = `ADDR_STATUS_CONTROL;
    localparam logic [7:0] RH = `ADDR_RESULT_HIGH;
    localparam logic [7:0] RL = `ADDR_RESULT_LOW;
    localparam logic [7:0] CK = `ADDR_CLOCK_CONFIG;
    localparam int LIMIT = 60000; // generous: run needs under two thousand
    logic        clk, sys_rst, psel, penable, pwrite, pready_r, pslverr_r;
    logic        alt_clk_tick, async_clk_tick, stop_mode, cmp_in, irq_r;
    logic        async_clk_req_r, low_power_config_r, sar_power_r;
    logic        sar_sample_r, err, ok;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata_r, q;
    logic [4:0]  sar_channel_r;
    logic [9:0]  sar_trial_r, level;
    logic [1:0]  alt_cnt = 2'h0;
    int          mismatches, n_tests, cycles, i;

    sar_adc_control u_sar_adc_control (.clk(clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
        .pslverr_r(pslverr_r), .alt_clk_tick(alt_clk_tick),
        .async_clk_tick(async_clk_tick), .stop_mode(stop_mode),
        .cmp_in(cmp_in), .async_clk_req_r(async_clk_req_r),
        .low_power_config_r(low_power_config_r), .sar_power_r(sar_power_r),
        .sar_sample_r(sar_sample_r), .sar_channel_r(sar_channel_r),
        .sar_trial_r(sar_trial_r), .irq_r(irq_r));
    sar_analog_model u_sar_analog_model (.clk(clk), .sar_power_r(sar_power_r),
        .sar_trial_r(sar_trial_r), .level(level), .cmp_in(cmp_in));

    // 4 ns bus clock
    always #2 clk = ~clk;

    // bus clock never slower than converter clock, alt edge every third
    always @(posedge clk) begin
        alt_cnt <= (alt_cnt == 2'h2) ? 2'h0 : alt_cnt + 2'h1;
        alt_clk_tick <= (alt_cnt == 2'h2);
        // async source stands still unless the block asks for it
        async_clk_tick <= async_clk_req_r & ~async_clk_tick;
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; setup, then access until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready_r !== 1'b1 && n < 16) begin
            n++;
            @(posedge clk);
        end
        q = prdata_r;
        err = pslverr_r;
        if (n == 16) chk(32'h0000_0000, 32'h0000_0001);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask

    // poll the done flag, bounded
    task automatic wait_done();
        int n;
        n = 0;
        q = 32'h0000_0000;
        while (q[`SC_DONE_BIT] !== 1'b1 && n < 400) begin
            n++;
            apb(1'b0, SC, 32'h0000_0000);
        end
        chk(32'(n < 400), 32'h0000_0001);
    endtask

    // converter must stay unpowered for a while
    task automatic idle_check();
        ok = 1'b1;
        repeat (60) begin
            @(posedge clk);
            if (sar_power_r !== 1'b0) ok = 1'b0;
        end
    endtask

    // count alternate edges inside the sampling phase
    task automatic measure(input logic [7:0] ck_val, input int exp);
        int t, n;
        t = 0;
        n = 0;
        apb(1'b1, CK, {24'h0, ck_val});
        apb(1'b1, SC, 32'h0000_0000);
        while (sar_sample_r !== 1'b1 && n < 200) begin
            n++;
            @(posedge clk);
        end
        while (sar_sample_r === 1'b1 && n < 2000) begin
            n++;
            if (alt_clk_tick === 1'b1) t++;
            @(posedge clk);
        end
        ok = (t >= exp - 1) && (t <= exp + 1);
        wait_done();
    endtask

    // rounded 8-bit result of a 10-bit level, saturating
    function automatic logic [31:0] exp8(input logic [9:0] l);
        return (l > 10'h3FD) ? 32'h0000_00FF : {22'h0, (l + 10'h002) >> 2};
    endfunction

    task automatic end_sim();
        if (mismatches == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        {psel, penable, pwrite} = 3'h0;
        stop_mode = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        level = 10'h000;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        chk(sar_channel_r, 32'h0000_001F);
        rdc(SC, 32'h0000_001F);
        rdc(CK, 32'h0000_0000);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk({err, q[30:0]}, 32'h8000_0000);
        apb(1'b1, CK, 32'h0000_00A6);
        rdc(CK, 32'h0000_00A6);
        chk(low_power_config_r, 32'h0000_0001);
        // 8-bit single with interrupt enabled on channel 3
        level <= 10'h1FE;
        apb(1'b1, CK, 32'h0000_0010);
        apb(1'b1, SC, 32'h0000_0043);
        @(posedge clk);
        chk(sar_channel_r, 32'h0000_0003);
        wait_done();
        chk(irq_r, 32'h0000_0001);
        rdc(RH, 32'h0000_0000);
        @(posedge clk);
        chk(irq_r, 32'h0000_0000);
        rdc(RL, exp8(10'h1FE));
        rdc(SC, 32'h0000_0043);
        chk(sar_power_r, 32'h0000_0000);
        // restart mid conversion, second level must win
        level <= 10'h200;
        apb(1'b1, SC, 32'h0000_0000);
        repeat (8) @(posedge clk);
        level <= 10'h008;
        apb(1'b1, SC, 32'h0000_0000);
        wait_done();
        rdc(RL, exp8(10'h008));
        // 10-bit single, interrupt disabled
        level <= 10'h2A5;
        apb(1'b1, CK, 32'h0000_0014);
        apb(1'b1, SC, 32'h0000_0019);
        wait_done();
        chk(irq_r, 32'h0000_0000);
        rdc(RH, 32'h0000_0002);
        rdc(RL, 32'h0000_00A5);
        repeat (60) @(posedge clk);
        rdc(SC, 32'h0000_0019);
        // continuous 10-bit with high-read lock
        level <= 10'h155;
        apb(1'b1, SC, 32'h0000_003A);
        wait_done();
        rdc(RH, 32'h0000_0001);
        level <= 10'h0CC;
        repeat (60) @(posedge clk);
        rdc(RL, 32'h0000_0055);
        repeat (60) @(posedge clk);
        rdc(RH, 32'h0000_0000);
        rdc(RL, 32'h0000_00CC);
        // 8-bit continuous has no lock
        apb(1'b1, CK, 32'h0000_0010);
        apb(1'b1, SC, 32'h0000_003A);
        wait_done();
        apb(1'b0, RH, 32'h0000_0000);
        level <= 10'h040;
        repeat (60) @(posedge clk);
        rdc(RL, exp8(10'h040));
        // channel off ends continuous with no extra conversion
        apb(1'b1, SC, 32'h0000_003F);
        idle_check();
        chk(ok, 32'h0000_0001);
        // clock register write ends continuous
        apb(1'b1, SC, 32'h0000_003A);
        wait_done();
        apb(1'b1, CK, 32'h0000_0010);
        idle_check();
        chk(ok, 32'h0000_0001);
        // stop without async clock aborts and stays halted
        level <= 10'h0CC;
        apb(1'b1, SC, 32'h0000_003A);
        wait_done();
        rdc(RL, exp8(10'h0CC));
        level <= 10'h300;
        stop_mode <= 1'b1;
        repeat (4) @(posedge clk);
        stop_mode <= 1'b0;
        idle_check();
        chk(ok, 32'h0000_0001);
        rdc(RL, exp8(10'h0CC));
        // async clock keeps a conversion going through stop
        apb(1'b1, CK, 32'h0000_0001);
        apb(1'b1, SC, 32'h0000_0000);
        for (i = 0; i < 100 && async_clk_req_r !== 1'b1; i++) @(posedge clk);
        chk(async_clk_req_r, 32'h0000_0001);
        stop_mode <= 1'b1;
        wait_done();
        stop_mode <= 1'b0;
        chk(async_clk_req_r, 32'h0000_0000);
        rdc(RL, exp8(10'h300));
        // divider codes and sample length on the alternate source
        for (i = 0; i < 4; i++) begin
            measure(8'(i << 5), 4 << i);
            chk(ok, 32'h0000_0001);
        end
        measure(8'h02, 24);
        chk(ok, 32'h0000_0001);
        end_sim();
    end
endmodule
